/* rtl/flash_error_status_freeze_lock.sv */
// Serial flash status, error and freeze-lock logic with APB view.
// Assumes serial pins asynchronous to core_clk; array_fail on core_clk.
`timescale 1ns/10ps
module flash_error_status_freeze_lock
  import flash_pkg::*;
#(
  parameter int OP_CYCLES = 256
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        reset_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_n,
  // Array side
  input  wire logic        array_fail,
  output logic             op_done,
  // Interrupt
  output logic             irq
);
  import flash_pkg::*;

  logic [PIN_W-1:0] pins_s;
  logic        sck_d_ff, cs_d_ff;
  logic        sck_rise, sck_fall, cs_start, cs_end, hw_rst;
  spi_state_t  state_ff, nxt_state;
  logic [7:0]  kind_ff;
  logic [31:0] sh_ff, nxt_sh;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic [ADDR_W-1:0] addr_ff;
  logic [9:0]  byte_cnt_ff;
  logic [7:0]  dbyte0_ff, dbyte1_ff;
  logic [7:0]  out_sh_ff;
  logic [3:0]  ctrl_ff;
  logic [1:0]  lanes;
  logic        ddr_act, take, out_edge, byte_done;
  logic        wip_ff, p_err_ff, e_err_ff;
  logic        busy_ff, is_erase_ff;
  logic [15:0] op_cnt_ff;
  logic [7:0]  sr_nv, cr_nv, cr_v, sr_v;
  logic [2:0]  bp_v;
  logic        exec, do_sr, do_cr, do_clr, start_op, otp_refuse, prot_hit;
  logic        err_now, op_end, freeze;
  logic [7:0]  prot_n, sect;
  logic [EVT_W-1:0] evt_ff, mask_ff, evt_in;
  logic        op_done_ff, irq_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic [3:0]  io_out_ff, io_oe_n_ff;
  logic        apb_wr;
  logic        skip_ff;

  pin_sync #(.W(PIN_W), .RST_V(PIN_RESET)) u_pins (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({sck, cs_n, reset_n, io_in}),
    .level_ff (pins_s)
  );

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_d_ff <= 1'b0;
      cs_d_ff  <= 1'b1;
    end
    else
    begin
      sck_d_ff <= pins_s[6];
      cs_d_ff  <= pins_s[5];
    end
  end

  assign sck_rise = pins_s[6] & ~sck_d_ff;
  assign sck_fall = ~pins_s[6] & sck_d_ff;
  assign cs_start = cs_d_ff & ~pins_s[5];
  assign cs_end   = ~cs_d_ff & pins_s[5];
  assign hw_rst   = ~pins_s[4];
  assign freeze   = cr_v[CR_FREEZE];

  assign lanes   = (state_ff == ST_CMD) ? (ctrl_ff[CTRL_QPI] ? LANES_FOUR : LANES_ONE)
                                        : ctrl_ff[CTRL_LANES_LO +: 2];
  assign ddr_act = ctrl_ff[CTRL_DDR] && (lanes == LANES_FOUR) && (state_ff != ST_CMD);
  assign take    = ((state_ff == ST_CMD) || (state_ff == ST_ADDR) || (state_ff == ST_DIN))
                   && (sck_rise || (ddr_act && sck_fall));
  assign out_edge = (state_ff == ST_DOUT) && (sck_fall || (ddr_act && sck_rise));

  always_comb
  begin
    nxt_sh  = sh_ff;
    nxt_cnt = cnt_ff;
    if (take)
    begin
      case (lanes)
        LANES_TWO:  begin nxt_sh = {sh_ff[29:0], pins_s[1:0]}; nxt_cnt = cnt_ff + 6'h02; end
        LANES_FOUR: begin nxt_sh = {sh_ff[27:0], pins_s[3:0]}; nxt_cnt = cnt_ff + 6'h04; end
        default:    begin nxt_sh = {sh_ff[30:0], pins_s[0]};   nxt_cnt = cnt_ff + 6'h01; end
      endcase
    end
  end
  assign byte_done = take && (nxt_cnt == BITS_BYTE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (cs_start) nxt_state = ST_CMD;
      ST_CMD:
        if (byte_done)
        begin
          case (nxt_sh[7:0])
            OPC_RD_STATUS: nxt_state = ST_DOUT;
            OPC_CLR_STAT:  nxt_state = ST_DONE;
            OPC_REG_WRITE: nxt_state = wip_ff ? ST_DONE : ST_DIN;
            OPC_PROGRAM, OPC_ERASE, OPC_OTP_PROG:
              nxt_state = wip_ff ? ST_DONE : ST_ADDR;
            default:       nxt_state = ST_DONE;
          endcase
        end
      ST_ADDR:
        if (take && nxt_cnt == BITS_ADDR)
          nxt_state = (kind_ff == OPC_ERASE) ? ST_DONE : ST_DIN;
      ST_DIN, ST_DOUT, ST_DONE: nxt_state = state_ff;
      default: nxt_state = ST_IDLE;
    endcase
    if (cs_end || hw_rst)
      nxt_state = ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_ff   <= '0;
      cnt_ff  <= '0;
      kind_ff <= '0;
      addr_ff <= '0;
    end
    else if (state_ff == ST_IDLE)
    begin
      cnt_ff  <= '0;
      kind_ff <= '0;
    end
    else
    begin
      sh_ff  <= nxt_sh;
      cnt_ff <= (byte_done && state_ff != ST_ADDR) ? '0 : nxt_cnt;
      if (state_ff == ST_CMD && byte_done)
        kind_ff <= nxt_sh[7:0];
      if (state_ff == ST_ADDR && take && nxt_cnt == BITS_ADDR)
      begin
        addr_ff <= nxt_sh[ADDR_W-1:0];
        cnt_ff  <= '0;
      end
    end
  end

  // count page bytes, capped at the buffer size
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      byte_cnt_ff <= '0;
      dbyte0_ff   <= '0;
      dbyte1_ff   <= '0;
    end
    else if (cs_start)
      byte_cnt_ff <= '0;
    else if (state_ff == ST_DIN && byte_done)
    begin
      if (byte_cnt_ff == '0)
        dbyte0_ff <= nxt_sh[7:0];
      if (byte_cnt_ff == 10'h001)
        dbyte1_ff <= nxt_sh[7:0];
      if (byte_cnt_ff != PAGE_MAX)
        byte_cnt_ff <= byte_cnt_ff + 10'h001;
    end
  end

  // Commands act only when the host ends the frame
  assign exec     = cs_end && !hw_rst;
  assign do_sr    = exec && kind_ff == OPC_REG_WRITE && state_ff == ST_DIN
                    && byte_cnt_ff != '0;
  assign do_cr    = do_sr && byte_cnt_ff >= 10'h002;
  assign do_clr   = exec && kind_ff == OPC_CLR_STAT;
  assign otp_refuse = exec && kind_ff == OPC_OTP_PROG && state_ff == ST_DIN && freeze;
  assign start_op = exec && !otp_refuse && (
                    (kind_ff == OPC_ERASE && state_ff == ST_DONE && cnt_ff == '0
                     && addr_ff != '1) ||
                    ((kind_ff == OPC_PROGRAM || kind_ff == OPC_OTP_PROG)
                     && state_ff == ST_DIN && byte_cnt_ff != '0));

  // Protected range grows from the top, or bottom with origin select
  assign sect   = {1'b0, addr_ff[SECT_HI:SECT_LO]};
  assign prot_n = (bp_v == BP_NONE) ? 8'h00 :
                  (bp_v == BP_ALL)  ? SECTORS : (8'h01 << (bp_v - 3'h1));
  assign prot_hit = (kind_ff != OPC_OTP_PROG) &&
                    (cr_nv[CR_TBPROT] ? (sect < prot_n) : (sect >= SECTORS - prot_n));

  assign op_end  = busy_ff && op_cnt_ff == 16'(OP_CYCLES - 1);
  // protected target or internal failure is an error
  assign err_now = (start_op && prot_hit) || (op_end && array_fail);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_ff     <= 1'b0;
      is_erase_ff <= 1'b0;
      op_cnt_ff   <= '0;
      op_done_ff  <= 1'b0;
    end
    else
    begin
      op_done_ff <= 1'b0;
      if (hw_rst)
        busy_ff <= 1'b0;
      else if (start_op)
      begin
        busy_ff     <= !prot_hit;
        is_erase_ff <= kind_ff == OPC_ERASE;
        op_cnt_ff   <= '0;
      end
      else if (op_end)
      begin
        busy_ff    <= 1'b0;
        op_done_ff <= !array_fail;
      end
      else if (busy_ff)
        op_cnt_ff <= op_cnt_ff + 16'h0001;
    end
  end

  // flags hold until clear-status or reset pin
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wip_ff   <= 1'b0;
      p_err_ff <= 1'b0;
      e_err_ff <= 1'b0;
    end
    else if (hw_rst)
    begin
      wip_ff   <= 1'b0;
      p_err_ff <= 1'b0;
      e_err_ff <= 1'b0;
    end
    else if (err_now)
    begin
      wip_ff <= 1'b1;
      if ((start_op ? kind_ff == OPC_ERASE : is_erase_ff))
        e_err_ff <= 1'b1;
      else
        p_err_ff <= 1'b1;
    end
    else if (start_op)
      wip_ff <= 1'b1;
    else if (op_end)
      wip_ff <= 1'b0;
    else if (do_clr && (p_err_ff || e_err_ff))
    begin
      wip_ff   <= 1'b0;
      p_err_ff <= 1'b0;
      e_err_ff <= 1'b0;
    end
  end

  lock_reg #(.W(8), .RST_V(SR_NV_RESET)) u_sr_nv (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .load_en   (1'b0),
    .load_val  (8'h00),
    .wr_en     (do_sr),
    .wdata     (dbyte0_ff),
    .lock_mask ({3'h0, {3{freeze}}, 2'h3})
  , .q_ff      (sr_nv)
  );
  lock_reg #(.W(3), .RST_V(SR_NV_RESET[SR_BP_HI:SR_BP_LO])) u_bp_v (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .load_en   (hw_rst),
    .load_val  (sr_nv[SR_BP_HI:SR_BP_LO]),
    .wr_en     (do_sr),
    .wdata     (dbyte0_ff[SR_BP_HI:SR_BP_LO]),
    .lock_mask ({3{freeze}}),
    .q_ff      (bp_v)
  );
  // config bits 2, 3 and 5 locked by freeze
  lock_reg #(.W(8), .RST_V(CR_NV_RESET)) u_cr_nv (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .load_en   (1'b0),
    .load_val  (8'h00),
    .wr_en     (do_cr),
    .wdata     ({dbyte1_ff[7:1], 1'b0}),
    .lock_mask (freeze ? CR_LOCK_MASK : 8'h00)
  , .q_ff      (cr_nv)
  );
  // Freeze itself cannot be cleared except by reset
  lock_reg #(.W(8), .RST_V(CR_NV_RESET)) u_cr_v (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .load_en   (hw_rst),
    .load_val  ({cr_nv[7:1], 1'b0}),
    .wr_en     (do_cr),
    .wdata     (dbyte1_ff),
    .lock_mask (freeze ? (CR_LOCK_MASK | 8'h01) : 8'h00),
    .q_ff      (cr_v)
  );

  always_comb
  begin
    sr_v = sr_nv;
    sr_v[SR_WIP] = wip_ff;
    sr_v[SR_BP_HI:SR_BP_LO] = bp_v;
    sr_v[SR_E_ERR] = e_err_ff;
    sr_v[SR_P_ERR] = p_err_ff;
  end

  // status read out: enables and first bits follow the opcode lanes (one or four), later bits the lane field
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_sh_ff  <= '0;
      io_out_ff  <= '0;
      io_oe_n_ff <= 4'hF;
      skip_ff    <= 1'b0;
    end
    else if (state_ff != ST_DOUT)
    begin
      out_sh_ff  <= sr_v;
      io_oe_n_ff <= 4'hF;
      // Falling edge ending the opcode must not move the first bit
      skip_ff    <= 1'b1;
      if (nxt_state == ST_DOUT)
      begin
        case (lanes)
          LANES_TWO:  begin io_out_ff <= {2'h0, sr_v[7:6]};      io_oe_n_ff <= 4'hC; end
          LANES_FOUR: begin io_out_ff <= sr_v[7:4];              io_oe_n_ff <= 4'h0; end
          default:    begin io_out_ff <= {2'h0, sr_v[7], 1'b0};  io_oe_n_ff <= 4'hD; end
        endcase
        out_sh_ff <= sr_v;
      end
    end
    else if (out_edge && skip_ff)
      skip_ff <= 1'b0;
    else if (out_edge)
    begin
      case (lanes)
        LANES_TWO:
        begin
          io_out_ff <= {2'h0, (out_sh_ff[5:0] == 6'h0 && 1'b0) ? 2'h0 : out_sh_ff[5:4]};
          out_sh_ff <= (out_sh_ff[3:0] == 4'h0 && 1'b0) ? sr_v : {out_sh_ff[5:0], 2'h0};
        end
        LANES_FOUR:
        begin
          io_out_ff <= out_sh_ff[3:0];
          out_sh_ff <= {out_sh_ff[3:0], 4'h0};
        end
        default:
        begin
          io_out_ff <= {2'h0, out_sh_ff[6], 1'b0};
          out_sh_ff <= {out_sh_ff[6:0], 1'b0};
        end
      endcase
    end
  end

  // APB: one access cycle, registered answer
  assign apb_wr = psel && penable && pready_ff && pwrite;
  assign evt_in = {otp_refuse, do_clr, op_done_ff, err_now};

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
    else
    begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !(paddr == OFS_REG_VIEW || paddr == OFS_CTRL ||
                    paddr == OFS_EVT || paddr == OFS_MASK || paddr == OFS_PAGE_COUNT);
      prdata_ff  <= '0;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          OFS_REG_VIEW:   prdata_ff <= {cr_nv, cr_v, sr_nv, sr_v};
          OFS_CTRL:       prdata_ff <= {28'h0, ctrl_ff};
          OFS_EVT:        prdata_ff <= {28'h0, evt_ff};
          OFS_MASK:       prdata_ff <= {28'h0, mask_ff};
          OFS_PAGE_COUNT: prdata_ff <= {22'h0, byte_cnt_ff};
          default:        prdata_ff <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_ff <= CTRL_RESET;
      mask_ff <= '0;
    end
    else if (apb_wr && paddr == OFS_CTRL)
      ctrl_ff <= pwdata[3:0];
    else if (apb_wr && paddr == OFS_MASK)
      mask_ff <= pwdata[EVT_W-1:0];
  end

  // New events win over a same-cycle write-one clear
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      evt_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      evt_ff <= (evt_ff & ~((apb_wr && paddr == OFS_EVT) ? pwdata[EVT_W-1:0] : '0)) | evt_in;
      irq_ff <= |(evt_ff & mask_ff);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign io_out  = io_out_ff;
  assign io_oe_n = io_oe_n_ff;
  assign op_done = op_done_ff;
  assign irq     = irq_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_err_sets_wip: assert property (err_now && !hw_rst |=> wip_ff && (p_err_ff || e_err_ff))
    else $error("error did not set flags");
  chk_err_sticky: assert property ((p_err_ff || e_err_ff) && !do_clr && !hw_rst |=> wip_ff
    && $stable(p_err_ff) && $stable(e_err_ff))
    else $error("error flags dropped");
  chk_clear_status: assert property (do_clr && (p_err_ff || e_err_ff) && !err_now |=>
    !wip_ff && !p_err_ff && !e_err_ff && state_ff == ST_IDLE)
    else $error("clear-status failed");
  chk_no_done_err: assert property (op_end && array_fail |=> !op_done_ff ##1 wip_ff)
    else $error("failed operation completed");
  chk_freeze_bp: assert property (freeze && !hw_rst |=> $stable(bp_v)
    && $stable(sr_nv[SR_BP_HI:SR_BP_LO]))
    else $error("frozen protection bits changed");
  chk_freeze_cfg: assert property (freeze |=> $stable(cr_nv & CR_LOCK_MASK))
    else $error("frozen config bits changed");
  chk_page_cap: assert property (byte_cnt_ff <= PAGE_MAX)
    else $error("page count beyond buffer");
  chk_one_byte: assert property (do_sr && byte_cnt_ff == 10'h001 |=> $stable(cr_v)
    && $stable(cr_nv))
    else $error("single byte write touched config");
  chk_hw_reset: assert property (hw_rst |=> state_ff == ST_IDLE && !wip_ff && !busy_ff)
    else $error("reset pin did not return to standby");
  chk_otp_refuse: assert property (otp_refuse |=> !busy_ff && $stable(wip_ff))
    else $error("frozen OTP write started");
  chk_ddr_edges: assert property (ddr_act && sck_fall && state_ff == ST_ADDR |=>
    cnt_ff != $past(cnt_ff))
    else $error("DDR falling edge not sampled");
endmodule : flash_error_status_freeze_lock

/* rtl/flash_pkg.sv */
// Constants shared by the flash status and freeze-lock block.
// Assumes a 125 MHz core clock and an APB master with 32-bit data.
package flash_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_REG_VIEW   = 8'h00;
  localparam logic [7:0] OFS_CTRL       = 8'h04;
  localparam logic [7:0] OFS_EVT        = 8'h08;
  localparam logic [7:0] OFS_MASK       = 8'h0C;
  localparam logic [7:0] OFS_PAGE_COUNT = 8'h10;
  // Control register fields
  localparam int CTRL_LANES_LO = 0;
  localparam int CTRL_DDR      = 2;
  localparam int CTRL_QPI      = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Lane width codes
  localparam logic [1:0] LANES_ONE  = 2'h0;
  localparam logic [1:0] LANES_TWO  = 2'h1;
  localparam logic [1:0] LANES_FOUR = 2'h2;
  // Event bits, same layout in the mask
  localparam int EVT_W         = 4;
  localparam int EVT_ERROR     = 0;
  localparam int EVT_OP_DONE   = 1;
  localparam int EVT_CLEARED   = 2;
  localparam int EVT_OTP_REFUSE = 3;
  // Serial opcodes
  localparam logic [7:0] OPC_REG_WRITE = 8'h01;
  localparam logic [7:0] OPC_PROGRAM   = 8'h02;
  localparam logic [7:0] OPC_RD_STATUS = 8'h05;
  localparam logic [7:0] OPC_CLR_STAT  = 8'h30;
  localparam logic [7:0] OPC_OTP_PROG  = 8'h42;
  localparam logic [7:0] OPC_ERASE     = 8'hD8;
  // Status one fields
  localparam int SR_WIP   = 0;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 4;
  localparam int SR_E_ERR = 5;
  localparam int SR_P_ERR = 6;
  // Config one fields
  localparam int CR_FREEZE = 0;
  localparam int CR_TBPARM = 2;
  localparam int CR_BPNV   = 3;
  localparam int CR_TBPROT = 5;
  localparam logic [7:0] CR_LOCK_MASK = 8'h2C;
  localparam logic [7:0] SR_NV_RESET  = 8'h00;
  localparam logic [7:0] CR_NV_RESET  = 8'h00;
  localparam logic [2:0] BP_NONE      = 3'h0;
  localparam logic [2:0] BP_ALL       = 3'h7;
  // Serial framing
  localparam logic [5:0] BITS_BYTE = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h18;
  localparam int ADDR_W   = 24;
  localparam int SECT_LO  = 16;
  localparam int SECT_HI  = 22;
  localparam logic [7:0] SECTORS = 8'h80;
  localparam logic [9:0] PAGE_MAX = 10'h200;
  // Pin vector layout: sck, cs_n, reset_n, io[3:0]
  localparam int PIN_W = 7;
  // Idle pin levels: clock low, select high, reset pin released
  localparam logic [6:0] PIN_RESET = 7'h30;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD  = 6'h02,
    ST_ADDR = 6'h04,
    ST_DIN  = 6'h08,
    ST_DOUT = 6'h10,
    ST_DONE = 6'h20
  } spi_state_t;
endpackage : flash_pkg

/* rtl/lock_reg.sv */
// Register with per-bit write lock and a reload path.
// Assumes the caller accepts that reload always takes priority over write.
`timescale 1ns/10ps
module lock_reg #(
  parameter int           W     = 8,
  parameter logic [W-1:0] RST_V = '0
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Reload beats write
  input  wire logic         load_en,
  input  wire logic [W-1:0] load_val,
  // Write with locked bits
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] lock_mask,
  output logic      [W-1:0] q_ff
);
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      q_ff <= RST_V;
    else if (load_en)
      q_ff <= load_val;
    else if (wr_en)
      // Locked bits keep their value, the rest update
      q_ff <= (q_ff & lock_mask) | (wdata & ~lock_mask);
  end
endmodule : lock_reg

/* rtl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to the clock.
`timescale 1ns/10ps
module pin_sync #(
  parameter int          W     = 1,
  parameter logic [W-1:0] RST_V = '0
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Pins in, filtered level out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_ff
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff    <= RST_V;
      s2_ff    <= RST_V;
      s3_ff    <= RST_V;
      level_ff <= RST_V;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Change counts only once stages two and three agree
      for (int i = 0; i < W; i++)
      begin
        if (s2_ff[i] == s3_ff[i])
          level_ff[i] <= s3_ff[i];
      end
    end
  end
endmodule : pin_sync

/* tb/spi_host_model.sv */
// Single-lane serial host model, mode 0, MSB first.
// Assumes callers wait for send to return before the next frame.
`timescale 1ns/10ps
module spi_host_model (
  // Serial pins toward the device
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in,
  // Serial data back from the device
  input  wire logic [3:0] io_out
);
  initial
  begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'h5;
  end

  // Idle data lines wander so no stale bit looks valid
  always #8 if (cs_n) io_in = ~io_in;

  task automatic send(input logic [63:0] w, input int nb);
    cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < nb * 8; i++)
    begin
      io_in[0] = w[63-i];
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    #250;
  endtask : send

  // status read: opcode out on io0, byte back on io1 at rising edges
  task automatic rd_status(input logic [7:0] op, output logic [7:0] s);
    cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < 16; i++)
    begin
      if (i < 8)
        io_in[0] = op[7-i];
      #62.5 sck = 1'b1;
      if (i >= 8)
        s[15-i] = io_out[1];
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    #250;
  endtask : rd_status
endmodule : spi_host_model

/* tb/testbench.sv */
// Self-checking bench for the flash status and freeze-lock block.
// Assumes the host model on the serial pins and APB driven here.
`timescale 1ns/10ps
module testbench;
  import flash_pkg::*;
  logic core_clk, rstn, psel, penable, pwrite, reset_n, array_fail;
  logic [7:0] paddr, rnd;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sck, cs_n, op_done, irq;
  logic [3:0] io_in, io_out, io_oe_n;
  logic [7:0] st;
  logic [32:0] exp_q[$], msk_q[$];
  int fail_count, total_checks, cyc, dones;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;

  flash_error_status_freeze_lock #(.OP_CYCLES(8)) u_dut (.core_clk(core_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n),
    .reset_n(reset_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .array_fail(array_fail), .op_done(op_done), .irq(irq));
  spi_host_model u_host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    total_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Request held from setup until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    if (!wr)
    begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr

  task automatic frame(input logic [63:0] w, input int nb);
    u_host.send(w, nb);
    repeat (40) @(posedge core_clk);
  endtask : frame

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Result watcher: oldest note against each completed read
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());

  always @(posedge core_clk)
  begin
    cyc++;
    if (op_done === 1'b1) dones++;
    if (cyc == 40000)
    begin
      fail_count++;
      end_sim();
    end
  end

  initial
  begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; reset_n = 1'b1; array_fail = 1'b0; rnd = 8'h1C;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    for (int a = 0; a <= 16; a += 4) rd(a[7:0], 33'h0, ALL);
    rd(8'h20, 33'h100000000, 33'h100000000);
    foreach (rnd[i]) rnd = lfsr(rnd);
    wr(OFS_MASK, {28'h0, rnd[3:0]});
    rd(OFS_MASK, {29'h0, rnd[3:0]}, ALL);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL, {28'h0, i == 0 ? 4'h0 : i == 1 ? 4'h1 : 4'hE});
      rd(OFS_CTRL, {29'h0, i == 0 ? 4'h0 : i == 1 ? 4'h1 : 4'hE}, ALL);
    end
    wr(OFS_CTRL, 32'h0);
    wr(OFS_MASK, 32'hF);
    frame({OPC_PROGRAM, 24'h0, 16'hA55A, 16'h0}, 6);
    chk({32'h0, dones == 1}, 33'h1);
    rd(OFS_PAGE_COUNT, 33'h2, ALL);
    array_fail <= 1'b1;
    frame({OPC_PROGRAM, 24'h0, 8'h3C, 24'h0}, 5);
    array_fail <= 1'b0;
    chk({32'h0, dones == 1}, 33'h1);
    rd(OFS_REG_VIEW, 33'h41, 33'hFF);
    frame({OPC_CLR_STAT, 56'h0}, 1);
    rd(OFS_REG_VIEW, 33'h0, 33'hFF);
    rd(OFS_EVT, 33'h7, ALL);
    frame({OPC_REG_WRITE, 8'h1C, 48'h0}, 2);
    rd(OFS_REG_VIEW, 33'h1C, 33'hFFFF00FF);
    frame({OPC_ERASE, 24'h0, 32'h0}, 4);
    repeat (50) @(posedge core_clk);
    rd(OFS_REG_VIEW, 33'h3D, 33'hFF);
    chk({32'h0, irq}, 33'h1);
    u_host.rd_status(OPC_RD_STATUS, st);
    chk({25'h0, st}, 33'h3D);
    chk({29'h0, io_oe_n}, 33'hF);
    frame({OPC_CLR_STAT, 56'h0}, 1);
    rd(OFS_REG_VIEW, 33'h1C, 33'hFF);
    wr(OFS_EVT, 32'hF);
    rd(OFS_EVT, 33'h0, ALL);
    chk({32'h0, irq}, 33'h0);
    frame({OPC_REG_WRITE, 8'h1C, 8'h01, 40'h0}, 3);
    frame({OPC_REG_WRITE, 8'h00, 8'h2C, 40'h0}, 3);
    rd(OFS_REG_VIEW, 33'h0001001C, 33'h2C2D001C);
    frame({OPC_OTP_PROG, 24'h0, 8'hFF, 24'h0}, 5);
    rd(OFS_EVT, 33'h8, 33'h8);
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(OFS_REG_VIEW, 33'h0, 33'h10061);
    end_sim();
  end
endmodule : testbench
